//--- sldcm_lane_cfg.sv
`timescale 1ns/100ps
`include "sldcm_defines.svh"

module sldcm_lane_cfg #(
	parameter int unsigned SD_AST_STEP_CYC = `SLDCM_AST_STEP_US * `SLDCM_PCLK_MHZ,
	parameter int unsigned SD_DST_BASE_CYC = `SLDCM_DST_BASE_US * `SLDCM_PCLK_MHZ,
	parameter int unsigned SD_DST_STEP_CYC = `SLDCM_DST_STEP_US * `SLDCM_PCLK_MHZ
) (
	// Clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Signal detect
	input  wire logic                        sig_detect_raw,
	output logic                             sig_detect_filt,
	// Lane controls
	output logic                             fiber100_deser_handling_en,
	output logic                             rx_low_power_en,
	output logic                             tx_low_power_en,
	output logic                             lane_rst,
	// Lane data
	input  wire sldcm_pkg::sldcm_lane_data_t rx_deser_data,
	output sldcm_pkg::sldcm_lane_data_t      rx_data_out,
	input  wire sldcm_pkg::sldcm_lane_data_t tx_data_in,
	output sldcm_pkg::sldcm_lane_data_t      tx_ser_data,
	// Macro configuration bus loop
	output logic                             mcb_dout,
	output logic                             mcb_frame,
	input  wire logic                        mcb_din
);
	import sldcm_pkg::*;

	localparam int unsigned LW = $bits(sldcm_lane_data_t);
	localparam logic [5:0] FRAME_LAST = 6'(`SLDCM_MCB_FRAME - 1);
	localparam logic [5:0] LOOP_FIRST = 6'(`SLDCM_MCB_LOOP);
	localparam logic [5:0] RUN_LAST   = 6'(`SLDCM_MCB_FRAME + `SLDCM_MCB_LOOP - 1);

	logic [5:0]             dig_q;
	logic [8:0]             misc_q;
	logic [15:0]            sel_q;
	logic [15:0]            wdata_q;
	logic [15:0]            rdata_q;
	logic                   wr_busy_q;
	logic                   rd_busy_q;
	sldcm_state_t           state_q;
	logic [5:0]             cnt_q;
	logic [32:0]            sh_out_q;
	logic [32:0]            sh_in_q;
	logic                   frame_q;
	logic [31:0]            prdata_q;
	sldcm_lane_data_t       rx_q;
	sldcm_lane_data_t       tx_q;

	// Bus decode.
	wire        apb_setup  = psel & ~penable;
	wire        apb_access = psel & penable;
	wire        hit_dig    = paddr == `SLDCM_OFF_DIG;
	wire        hit_misc   = paddr == `SLDCM_OFF_MISC;
	wire        hit_mcb    = paddr == `SLDCM_OFF_MCB;
	wire        hit_wdata  = paddr == `SLDCM_OFF_WDATA;
	wire        hit_rdata  = paddr == `SLDCM_OFF_RDATA;
	wire        hit_stat   = paddr == `SLDCM_OFF_STAT;
	wire        addr_hit   = hit_dig | hit_misc | hit_mcb | hit_wdata | hit_rdata | hit_stat;
	wire        apb_wr     = apb_access & pwrite & addr_hit;
	wire        busy       = wr_busy_q | rd_busy_q;
	wire        wr_mcb     = apb_wr & hit_mcb;

	// Launches are taken only while idle; write wins if both are set.
	wire        launch_wr  = wr_mcb & pwdata[`SLDCM_WR_BIT] & ~busy;
	wire        launch_rd  = wr_mcb & pwdata[`SLDCM_RD_BIT] & ~pwdata[`SLDCM_WR_BIT] & ~busy;
	wire        launch     = launch_wr | launch_rd;
	wire [15:0] new_sel    = pwdata[`SLDCM_SEL_MSB:0];
	wire        run_end    = (state_q == SLDCM_RUN) && (cnt_q == RUN_LAST);
	wire        capture    = (state_q == SLDCM_RUN) && (cnt_q >= LOOP_FIRST);
	wire [32:0] sh_in_next = {mcb_din, sh_in_q[32:1]};

	wire [31:0] misc_rd    = {23'h000000, misc_q};
	wire [31:0] mcb_rd     = {wr_busy_q, rd_busy_q, 14'h0000, sel_q};
	wire [31:0] rd_mux     = hit_dig   ? {26'h0000000, dig_q} :
	                         hit_misc  ? misc_rd :
	                         hit_mcb   ? mcb_rd :
	                         hit_wdata ? {16'h0000, wdata_q} :
	                         hit_rdata ? {16'h0000, rdata_q} :
	                         hit_stat  ? {31'h00000000, sig_detect_filt} : 32'h00000000;

	assign pready  = 1'b1;
	assign pslverr = apb_access & ~addr_hit;
	assign prdata  = prdata_q;

	// Register file.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dig_q    <= `SLDCM_DIG_RST;
			misc_q   <= `SLDCM_MISC_RST;
			wdata_q  <= `SLDCM_WDATA_RST;
			prdata_q <= 32'h00000000;
		end else begin
			if (apb_wr && hit_dig) begin
				dig_q <= pwdata[`SLDCM_AST_MSB:`SLDCM_DST_LSB];
			end
			if (apb_wr && hit_misc) begin
				misc_q <= pwdata[8:0] & 9'h13d;
			end
			if (apb_wr && hit_wdata) begin
				wdata_q <= pwdata[15:0];
			end
			if (apb_setup) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// Selection vector changes only between transfers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= `SLDCM_SEL_RST;
		end else if (wr_mcb && !busy) begin
			sel_q <= new_sel;
		end
	end

	assign fiber100_deser_handling_en = misc_q[`SLDCM_FX100_BIT];
	assign rx_low_power_en            = misc_q[`SLDCM_RXLP_BIT];
	assign tx_low_power_en            = misc_q[`SLDCM_TXLP_BIT];
	assign lane_rst                   = misc_q[`SLDCM_LRST_BIT];

	// Lane data path; held at zero while the lane is in reset.
	wire [LW-1:0] rx_mask = {LW{misc_q[`SLDCM_RXINV_BIT]}};
	wire [LW-1:0] tx_mask = {LW{misc_q[`SLDCM_TXINV_BIT]}};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_q <= '0;
			tx_q <= '0;
		end else begin
			rx_q <= lane_rst ? '0 : rx_deser_data ^ rx_mask;
			tx_q <= lane_rst ? '0 : tx_data_in ^ tx_mask;
		end
	end

	assign rx_data_out = rx_q;
	assign tx_ser_data = tx_q;

	wire [2:0] ast_code_w = dig_q[`SLDCM_AST_MSB:`SLDCM_AST_LSB];

	// Signal detect filter.
	sldcm_sigdet_filter #(
		.AST_STEP_CYC (SD_AST_STEP_CYC),
		.DST_BASE_CYC (SD_DST_BASE_CYC),
		.DST_STEP_CYC (SD_DST_STEP_CYC)
	) u_sigdet (
		.pclk     (pclk),
		.presetn  (presetn),
		.ast_code (dig_q[`SLDCM_AST_MSB:`SLDCM_AST_LSB]),
		.dst_code (dig_q[`SLDCM_DST_MSB:`SLDCM_DST_LSB]),
		.sig_raw  (sig_detect_raw),
		.sig_filt (sig_detect_filt)
	);

	// Loop controller state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SLDCM_IDLE;
		end else begin
			unique case (state_q)
				SLDCM_IDLE: begin
					state_q <= launch ? SLDCM_RUN : SLDCM_IDLE;
				end
				SLDCM_RUN: begin
					state_q <= run_end ? SLDCM_IDLE : SLDCM_RUN;
				end
				default: begin
					state_q <= SLDCM_IDLE;
				end
			endcase
		end
	end

	// Frame is write flag, selection vector, then data, shifted out first bit first.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_out_q <= 33'h000000000;
			frame_q  <= 1'b0;
			cnt_q    <= 6'h00;
		end else if (state_q == SLDCM_IDLE) begin
			cnt_q <= 6'h00;
			if (launch) begin
				sh_out_q <= {wdata_q, new_sel, launch_wr};
				frame_q  <= 1'b1;
			end
		end else begin
			sh_out_q <= {1'b0, sh_out_q[32:1]};
			frame_q  <= cnt_q < FRAME_LAST;
			cnt_q    <= cnt_q + 6'h01;
		end
	end

	assign mcb_dout  = sh_out_q[0];
	assign mcb_frame = frame_q;

	// Returned frame capture and completion.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_in_q   <= 33'h000000000;
			rdata_q   <= 16'h0000;
			wr_busy_q <= 1'b0;
			rd_busy_q <= 1'b0;
		end else begin
			if (capture) begin
				sh_in_q <= sh_in_next;
			end
			if (run_end && rd_busy_q) begin
				rdata_q <= sh_in_next[32:17];
			end
			if (launch_wr) begin
				wr_busy_q <= 1'b1;
			end else if (run_end) begin
				wr_busy_q <= 1'b0;
			end
			if (launch_rd) begin
				rd_busy_q <= 1'b1;
			end else if (run_end) begin
				rd_busy_q <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_rx_invert: assert property (
		!lane_rst |=> rx_data_out == $past(rx_deser_data ^ {LW{misc_q[`SLDCM_RXINV_BIT]}}))
		else $error("Receive data not inverted as set.");
	a_tx_invert: assert property (
		!lane_rst |=> tx_ser_data == $past(tx_data_in ^ {LW{misc_q[`SLDCM_TXINV_BIT]}}))
		else $error("Transmit data not inverted as set.");
	a_lane_rst_held: assert property (
		(lane_rst && !(apb_wr && hit_misc)) |=> lane_rst)
		else $error("Lane reset cleared without a write.");
	a_misc_fields: assert property (
		(apb_wr && hit_misc) |=> fiber100_deser_handling_en == $past(pwdata[8])
		&& rx_low_power_en == $past(pwdata[5]) && tx_low_power_en == $past(pwdata[4]))
		else $error("Misc control outputs do not follow the write.");
	a_wr_busy_len: assert property (
		$rose(wr_busy_q) |-> ##48 wr_busy_q ##1 !wr_busy_q)
		else $error("Write busy did not last 49 cycles.");
	a_rd_busy_len: assert property (
		$rose(rd_busy_q) |-> ##48 rd_busy_q ##1 !rd_busy_q)
		else $error("Read busy did not last 49 cycles.");
	a_frame_len: assert property (
		$rose(mcb_frame) |-> ##32 mcb_frame ##1 !mcb_frame)
		else $error("Frame strobe not 33 cycles long.");
	a_frame_head: assert property (
		$rose(mcb_frame) |-> mcb_dout == wr_busy_q ##1 mcb_dout == sel_q[0])
		else $error("Frame head does not carry flag and vector.");
	a_launch_ignored: assert property (
		(busy && wr_mcb) |=> $stable(sel_q) && !$rose(mcb_frame))
		else $error("Launch accepted during a transfer.");
	a_sel_reset: assert property (
		$rose(presetn) |-> sel_q == 16'hffff)
		else $error("Selection vector not all ones after reset.");
	a_dig_write: assert property (
		(apb_wr && hit_dig) |=> dig_q == $past(pwdata[5:0]))
		else $error("Filter codes do not follow the write.");
	a_dig_hold: assert property (
		!(apb_wr && hit_dig) |=> $stable(dig_q))
		else $error("Filter codes changed without a write.");
	a_misc_hold: assert property (
		!(apb_wr && hit_misc) |=> $stable(misc_q))
		else $error("Misc controls changed without a write.");
	a_lane_rst_set: assert property (
		(apb_wr && hit_misc) |=> lane_rst == $past(pwdata[0]))
		else $error("Lane reset does not follow the write.");
	a_lane_rst_zero: assert property (
		lane_rst |=> rx_data_out == '0 && tx_ser_data == '0)
		else $error("Lane data not held at zero in lane reset.");
	a_sel_hold_busy: assert property (
		busy |=> $stable(sel_q))
		else $error("Selection vector changed during a transfer.");
	a_sel_write: assert property (
		(wr_mcb && !busy) |=> sel_q == $past(pwdata[15:0]))
		else $error("Selection vector does not follow an idle write.");
	a_one_launch: assert property (
		!(wr_busy_q && rd_busy_q))
		else $error("Write and read pending at once.");
	a_busy_run: assert property (
		busy == (state_q == SLDCM_RUN))
		else $error("Busy flags disagree with the loop state.");
	a_state_onehot: assert property (
		$onehot(state_q))
		else $error("Loop state is not one-hot.");
	a_launch_takes: assert property (
		launch |=> mcb_frame && busy)
		else $error("Launch did not start a frame.");
	a_wr_flag: assert property (
		launch_wr |=> wr_busy_q && !rd_busy_q)
		else $error("Write launch did not set only the write flag.");
	a_rd_flag: assert property (
		launch_rd |=> rd_busy_q && !wr_busy_q)
		else $error("Read launch did not set only the read flag.");
	a_rdata_hold: assert property (
		!(run_end && rd_busy_q) |=> $stable(rdata_q))
		else $error("Read result changed outside a read completion.");
	a_frame_tail: assert property (
		(state_q == SLDCM_RUN && !mcb_frame) |-> !mcb_dout)
		else $error("Serial output not quiet after the frame.");
	a_idle_no_frame: assert property (
		(state_q == SLDCM_IDLE) |-> !mcb_frame)
		else $error("Frame strobe high while idle.");
	a_wr_no_rdata: assert property (
		(run_end && wr_busy_q) |=> $stable(rdata_q))
		else $error("Write completion changed the read result.");
	a_ast_code_zero: assert property (
		(ast_code_w == 3'h0 && !sig_detect_filt && sig_detect_raw) |=> sig_detect_filt)
		else $error("Zero assertion delay did not pass at once.");

	c_read_launch: cover property (launch_rd);

	c_write_done: cover property ($fell(wr_busy_q));
	c_read_done: cover property ($fell(rd_busy_q));
	c_busy_launch: cover property (busy && wr_mcb && pwdata[`SLDCM_WR_BIT]);
	c_detect_rise: cover property ($rose(sig_detect_filt));

endmodule

//--- sldcm_defines.svh
`ifndef SLDCM_DEFINES_SVH
`define SLDCM_DEFINES_SVH

// Register byte offsets.
`define SLDCM_OFF_DIG       12'h000
`define SLDCM_OFF_MISC      12'h018
`define SLDCM_OFF_MCB       12'h020
`define SLDCM_OFF_WDATA     12'h024
`define SLDCM_OFF_RDATA     12'h028
`define SLDCM_OFF_STAT      12'h02c

// Field positions.
`define SLDCM_AST_MSB       5
`define SLDCM_AST_LSB       3
`define SLDCM_DST_MSB       2
`define SLDCM_DST_LSB       0
`define SLDCM_FX100_BIT     8
`define SLDCM_RXLP_BIT      5
`define SLDCM_TXLP_BIT      4
`define SLDCM_RXINV_BIT     3
`define SLDCM_TXINV_BIT     2
`define SLDCM_LRST_BIT      0
`define SLDCM_WR_BIT        31
`define SLDCM_RD_BIT        30
`define SLDCM_SEL_MSB       15

// Reset values.
`define SLDCM_DIG_RST       6'h00
`define SLDCM_MISC_RST      9'h000
`define SLDCM_SEL_RST       16'hffff
`define SLDCM_WDATA_RST     16'h0000

// Timing.
`define SLDCM_PCLK_MHZ      50
`define SLDCM_AST_STEP_US   35
`define SLDCM_DST_BASE_US   150
`define SLDCM_DST_STEP_US   100
`define SLDCM_MCB_FRAME     33
`define SLDCM_MCB_LOOP      16

`endif

//--- sldcm_pkg.sv
package sldcm_pkg;

	typedef logic [9:0] sldcm_lane_data_t;
	typedef logic [2:0] sldcm_sdcode_t;

	typedef enum logic [1:0] {
		SLDCM_IDLE = 2'b01,
		SLDCM_RUN  = 2'b10
	} sldcm_state_t;

endpackage

//--- sldcm_sigdet_filter.sv
`timescale 1ns/100ps
`include "sldcm_defines.svh"

module sldcm_sigdet_filter #(
	parameter int unsigned AST_STEP_CYC = 1750,
	parameter int unsigned DST_BASE_CYC = 7500,
	parameter int unsigned DST_STEP_CYC = 5000
) (
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// Filter setting
	input  wire sldcm_pkg::sldcm_sdcode_t ast_code,
	input  wire sldcm_pkg::sldcm_sdcode_t dst_code,
	// Detector
	input  wire logic                   sig_raw,
	output logic                        sig_filt
);
	import sldcm_pkg::*;

	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        filt_q;

	// Reserved codes act as the longest delay.
	function automatic logic [15:0] ast_cycles(input logic [2:0] c);
		logic [2:0] k;
		k = (c > 3'h4) ? 3'h4 : c;
		return 16'(k * AST_STEP_CYC);
	endfunction

	function automatic logic [15:0] dst_cycles(input logic [2:0] c);
		logic [2:0] k;
		k = (c > 3'h4) ? 3'h4 : c;
		return (k == 3'h0) ? 16'h0000 : 16'(DST_BASE_CYC + k * DST_STEP_CYC);
	endfunction

	wire [15:0] target_cyc = filt_q ? dst_cycles(dst_code) : ast_cycles(ast_code);
	wire        differ     = sig_raw != filt_q;
	wire        flip       = differ && (cnt_q >= target_cyc);

	assign cnt_d    = (differ && !flip) ? cnt_q + 16'h0001 : 16'h0000;
	assign sig_filt = filt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= 16'h0000;
			filt_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			filt_q <= flip ? sig_raw : filt_q;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_filt_cause: assert property ($changed(sig_filt) |-> sig_filt == $past(sig_raw))
		else $error("Filtered detect changed against the raw level.");
	a_zero_assert: assert property ((ast_code == 3'h0 && !sig_filt && sig_raw) |=> sig_filt)
		else $error("Zero assertion delay did not pass at once.");
	a_step_assert: assert property ((ast_code == 3'h1 && !sig_filt && sig_raw && cnt_q == 16'h0)
		|=> !sig_filt)
		else $error("Assertion delay shorter than one step.");

endmodule

//--- sldcm_mcb_loop_model.sv
`timescale 1ns/100ps
module sldcm_mcb_loop_model (
	// Clock
	input  wire logic pclk,
	// Loop
	input  wire logic mcb_dout,
	input  wire logic mcb_frame,
	output logic      mcb_din
);
	int          cyc = -1;
	int          k;
	logic [32:0] hist;
	logic [15:0] stored = 16'h0000;
	initial mcb_din = 1'b0;
	// Sixteen one-flop slaves return each frame bit sixteen cycles late, with the last written data in place of a read frame's data.
	always @(posedge pclk) begin
		k = (cyc >= 0) ? cyc : (mcb_frame ? 0 : -1);
		if (k >= 0 && k <= 32) hist[k] = mcb_dout;
		if (k >= 15 && k <= 47) begin
			if (!hist[0] && k >= 32) mcb_din <= stored[k - 32];
			else mcb_din <= hist[k - 15];
		end else mcb_din <= ~mcb_din;
		if (k == 48 && hist[0]) stored = hist[32:17];
		cyc = (k >= 0 && k < 48) ? k + 1 : -1;
	end
endmodule

//--- serdes_lane_digital_cfg_and_mcb_tb.sv
`timescale 1ns/100ps
`include "sldcm_defines.svh"
module serdes_lane_digital_cfg_and_mcb_tb;
	import sldcm_pkg::*;
	logic             pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic             sig_detect_raw = 0;
	logic [11:0]      paddr = 12'h000;
	logic [31:0]      pwdata = 32'h0, prdata, q, v, rng = 32'd76;
	logic             pready, pslverr, sig_detect_filt, e, mcb_dout, mcb_frame, mcb_din;
	logic             fiber100_deser_handling_en, rx_low_power_en, tx_low_power_en, lane_rst;
	sldcm_lane_data_t rx_deser_data = 10'h000, rx_data_out, tx_data_in = 10'h000, tx_ser_data;
	logic [33:0]      fb, fr;
	int               fails = 0, total_checks = 0, i, dig, misc, sel, wd, ak;

	always #10 pclk = ~pclk;

	sldcm_lane_cfg #(.SD_AST_STEP_CYC(3), .SD_DST_BASE_CYC(2), .SD_DST_STEP_CYC(2)) u_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .sig_detect_raw, .sig_detect_filt, .fiber100_deser_handling_en,
		.rx_low_power_en, .tx_low_power_en, .lane_rst, .rx_deser_data, .rx_data_out,
		.tx_data_in, .tx_ser_data, .mcb_dout, .mcb_frame, .mcb_din);
	sldcm_mcb_loop_model u_loop (.pclk, .mcb_dout, .mcb_frame, .mcb_din);

	function logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task test_done;
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		if (psel) @(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			fails++;
			test_done();
		end
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0);
		chk(q, exp);
	endtask

	task wait_idle;
		int n;
		for (n = 0; n < 100; n++) begin
			apb(0, `SLDCM_OFF_MCB, 32'h0);
			if (q[31:30] === 2'b00) break;
		end
		if (n == 100) begin
			fails++;
			test_done();
		end
	endtask

	// Drives the raw detector level and measures the filtered response time.
	task meas(input logic lvl, input int tgt);
		int n;
		sig_detect_raw <= lvl;
		for (n = 1; n < 40; n++) begin
			@(negedge pclk);
			if (sig_detect_filt === lvl) break;
		end
		chk(n, tgt + 2);
		@(posedge pclk);
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rdc(`SLDCM_OFF_DIG, 32'h0);
		rdc(`SLDCM_OFF_MISC, 32'h0);
		rdc(`SLDCM_OFF_MCB, 32'h0000ffff);
		apb(0, 12'h004, 32'h0);
		chk(32'(e), 32'h1);
		for (i = 0; i < 12; i++) begin
			v = xs();
			dig = v & 32'h3f;
			misc = (v >> 7) & 32'h13d;
			apb(1, `SLDCM_OFF_DIG, v);
			apb(1, `SLDCM_OFF_MISC, v >> 7);
			rdc(`SLDCM_OFF_DIG, dig);
			rdc(`SLDCM_OFF_MISC, misc);
			chk(32'(fiber100_deser_handling_en), 32'(misc[8]));
			chk(32'({rx_low_power_en, tx_low_power_en}), 32'(misc[5:4]));
			chk(32'(lane_rst), 32'(misc[0]));
			rx_deser_data <= v[9:0];
			tx_data_in <= v[25:16];
			@(posedge pclk);
			@(negedge pclk);
			chk(32'(rx_data_out), misc[0] ? 0 : 32'(v[9:0] ^ {10{misc[3]}}));
			chk(32'(tx_ser_data), misc[0] ? 0 : 32'(v[25:16] ^ {10{misc[2]}}));
			@(posedge pclk);
		end
		apb(1, `SLDCM_OFF_MISC, 32'h0);
		wd = xs() & 32'hffff;
		sel = xs() & 32'hffff;
		apb(1, `SLDCM_OFF_WDATA, wd);
		apb(1, `SLDCM_OFF_MCB, 32'h80000000 | sel);
		for (i = 0; i < 34; i++) begin
			@(negedge pclk);
			fb[i] = mcb_dout;
			fr[i] = mcb_frame;
		end
		@(posedge pclk);
		chk(32'(fr), 32'hffffffff);
		chk(32'(fr[33:32]), 32'h1);
		chk(32'(fb[0]), 32'h1);
		chk(32'(fb[16:1]), sel);
		chk(32'(fb[32:17]), wd);
		apb(1, `SLDCM_OFF_MCB, 32'h40000000 | (~sel & 32'hffff));
		rdc(`SLDCM_OFF_MCB, 32'h80000000 | sel);
		wait_idle();
		apb(1, `SLDCM_OFF_MCB, 32'h40000000 | sel);
		rdc(`SLDCM_OFF_MCB, 32'h40000000 | sel);
		wait_idle();
		rdc(`SLDCM_OFF_RDATA, wd);
		apb(1, `SLDCM_OFF_RDATA, ~wd);
		rdc(`SLDCM_OFF_RDATA, wd);
		for (i = 0; i < 8; i++) begin
			ak = (i > 4) ? 4 : i;
			apb(1, `SLDCM_OFF_DIG, (i << 3) | i);
			meas(1, ak * 3);
			rdc(`SLDCM_OFF_STAT, 32'h1);
			meas(0, (ak == 0) ? 0 : 2 + 2 * ak);
		end
		test_done();
	end
endmodule
